// ==== i2css_slave.v ====
// i2c slave serial port: apb register file, pin synchronisers, byte engine
//
// Contract
// - detect start, then set bus busy
// - shift seven address bits, compare own address
// - eighth bit stored as master read flag
// - address match sets flag, raises interrupt
// - drive acknowledge low on ninth clock
// - one interrupt for match and byte done
// - stretch scl until data buffer serviced
// - direction select bit picks transmit or receive
// - bytes are eight bits, msb first
// - receiver drives ack_to_send on ninth clock
// - transmitter records ack; no ack waits stop
// - data buffer feeds transmit, holds received byte
// - own address shares location with spi control
// - address in bits 7..1; bit 0 plain storage
// - byte complete low in transfer, high after
// - stop clears bus busy flag
// - mode value 110 selects i2c slave
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ns
`include "i2css_defs.vh"

module i2css_slave #(
    parameter ADDR_W = 12
) (
    input wire core_clk,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire scl_in,
    output wire scl_out,
    output wire scl_oe,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    output reg serial_irq_req
);

    // ------------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------------
    localparam [6:0] ST_IDLE = 7'h01;
    localparam [6:0] ST_ADDR = 7'h02;
    localparam [6:0] ST_AACK = 7'h04;
    localparam [6:0] ST_HOLD = 7'h08;
    localparam [6:0] ST_DATA = 7'h10;
    localparam [6:0] ST_DACK = 7'h20;
    localparam [6:0] ST_WSTOP = 7'h40;

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    reg [7:0] ctrl0_r;
    reg hcf_r;
    reg address_match_flag_r;
    reg hbb_r;
    reg htx_r;
    reg ack_to_send_r;
    reg srw_r;
    reg wake_r;
    reg ack_received_flag_r;
    reg [7:0] data_r;
    reg [7:0] own_addr_r;
    reg irq_en_r;
    reg [6:0] state_r;
    reg [3:0] cnt_r;
    reg [7:0] shift_r;
    reg sda_drv_r;
    reg scl_s1_r;
    reg scl_s2_r;
    reg scl_s3_r;
    reg sda_s1_r;
    reg sda_s2_r;
    reg sda_s3_r;
    reg active_d_r;
    reg scl_hold_r;

    // ------------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------------
    function [2:0] reg_sel;
        input [ADDR_W-1:0] a;
        begin
            if (a == `I2CSS_OFS_CTRL0) begin
                reg_sel = 3'h1;
            end else if (a == `I2CSS_OFS_CTRL1) begin
                reg_sel = 3'h2;
            end else if (a == `I2CSS_OFS_DATA) begin
                reg_sel = 3'h3;
            end else if (a == `I2CSS_OFS_ADDR) begin
                reg_sel = 3'h4;
            end else if (a == `I2CSS_OFS_IRQC) begin
                reg_sel = 3'h5;
            end else begin
                reg_sel = 3'h0;
            end
        end
    endfunction

    wire [2:0] sel = reg_sel(paddr);
    wire acc = psel & penable;
    wire wr_acc = acc & pwrite;
    wire rd_acc = acc & ~pwrite;
    wire data_wr = wr_acc & (sel == 3'h3);
    wire data_rd = rd_acc & (sel == 3'h3);

    assign pready = 1'b1;
    assign pslverr = acc & (sel == 3'h0);

    wire [7:0] ctrl1_rd = {hcf_r, address_match_flag_r, hbb_r, htx_r, ack_to_send_r, srw_r, wake_r, ack_received_flag_r};

    // read data is staged in the setup cycle so it comes from a flop
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h00000000;
        end else if (psel & ~penable & ~pwrite) begin
            if (sel == 3'h1) begin
                prdata <= {24'h000000, ctrl0_r};
            end else if (sel == 3'h2) begin
                prdata <= {24'h000000, ctrl1_rd};
            end else if (sel == 3'h3) begin
                prdata <= {24'h000000, data_r};
            end else if (sel == 3'h4) begin
                prdata <= {24'h000000, own_addr_r};
            end else if (sel == 3'h5) begin
                prdata <= {31'h00000000, irq_en_r};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------------------
    // software-owned configuration
    // ------------------------------------------------------------------------
    // the own address location also serves as the spi second control register
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl0_r <= `I2CSS_C0_RESET;
            htx_r <= 1'b0;
            ack_to_send_r <= 1'b0;
            wake_r <= 1'b0;
            own_addr_r <= `I2CSS_ADDR_RESET;
            irq_en_r <= 1'b0;
        end else if (wr_acc) begin
            if (sel == 3'h1) begin
                ctrl0_r <= pwdata[7:0] & `I2CSS_C0_WMASK;
            end else if (sel == 3'h2) begin
                htx_r <= pwdata[`I2CSS_C1_HTX];
                ack_to_send_r <= pwdata[`I2CSS_C1_ACK_TO_SEND];
                wake_r <= pwdata[`I2CSS_C1_WAKE];
            end else if (sel == 3'h4) begin
                own_addr_r <= pwdata[7:0];
            end else if (sel == 3'h5) begin
                irq_en_r <= pwdata[`I2CSS_IRQC_EN];
            end
        end
    end

    wire mode_ok = (ctrl0_r[`I2CSS_C0_MODE_HI:`I2CSS_C0_MODE_LO] == `I2CSS_MODE_I2C_SLAVE);
    wire active = mode_ok & ctrl0_r[`I2CSS_C0_EN];
    wire switch_on = active & ~active_d_r;

    // ------------------------------------------------------------------------
    // pin synchronisers and line events
    // ------------------------------------------------------------------------
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_s3_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_s3_r <= 1'b1;
            active_d_r <= 1'b0;
        end else begin
            scl_s1_r <= scl_in;
            scl_s2_r <= scl_s1_r;
            scl_s3_r <= scl_s2_r;
            sda_s1_r <= sda_in;
            sda_s2_r <= sda_s1_r;
            sda_s3_r <= sda_s2_r;
            active_d_r <= active;
        end
    end

    wire scl_rise = scl_s2_r & ~scl_s3_r;
    wire scl_fall = ~scl_s2_r & scl_s3_r;
    wire scl_high = scl_s2_r & scl_s3_r;
    // the slave never makes start itself; any start on the line restarts it
    wire start_ev = scl_high & sda_s3_r & ~sda_s2_r;
    wire stop_ev = scl_high & ~sda_s3_r & sda_s2_r;
    wire [7:0] shift_in = {shift_r[6:0], sda_s2_r};
    wire last_bit = (cnt_r == `I2CSS_BITS_PER_BYTE - 4'h1);
    wire byte_done = (cnt_r == `I2CSS_BITS_PER_BYTE);
    wire addr_hit = (shift_r[6:0] == own_addr_r[7:1]);
    wire release_ev = data_wr | data_rd;

    // ------------------------------------------------------------------------
    // byte engine
    // ------------------------------------------------------------------------
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            sda_drv_r <= 1'b0;
            hcf_r <= `I2CSS_HCF_RESET;
            address_match_flag_r <= 1'b0;
            hbb_r <= 1'b0;
            srw_r <= 1'b0;
            ack_received_flag_r <= `I2CSS_ACK_RECEIVED_FLAG_RESET;
            data_r <= `I2CSS_DATA_RESET;
            serial_irq_req <= 1'b0;
            scl_hold_r <= 1'b0;
        end else begin
            serial_irq_req <= 1'b0;
            scl_hold_r <= 1'b0;
            if (data_wr) begin
                data_r <= pwdata[7:0];
            end
            if (!active) begin
                state_r <= ST_IDLE;
                sda_drv_r <= 1'b0;
                cnt_r <= 4'h0;
            end else if (switch_on) begin
                state_r <= ST_IDLE;
                hcf_r <= `I2CSS_HCF_RESET;
                address_match_flag_r <= 1'b0;
                hbb_r <= 1'b0;
                srw_r <= 1'b0;
                ack_received_flag_r <= `I2CSS_ACK_RECEIVED_FLAG_RESET;
            end else if (start_ev) begin
                hbb_r <= 1'b1;
                address_match_flag_r <= 1'b0;
                sda_drv_r <= 1'b0;
                cnt_r <= 4'h0;
                state_r <= ST_ADDR;
            end else if (stop_ev) begin
                hbb_r <= 1'b0;
                sda_drv_r <= 1'b0;
                state_r <= ST_IDLE;
            end else begin
                case (state_r)
                    ST_ADDR: begin
                        if (scl_rise) begin
                            shift_r <= shift_in;
                            cnt_r <= cnt_r + 4'h1;
                            if (last_bit && addr_hit) begin
                                srw_r <= sda_s2_r;
                                address_match_flag_r <= 1'b1;
                                serial_irq_req <= irq_en_r;
                            end
                        end else if (scl_fall && byte_done) begin
                            if (address_match_flag_r) begin
                                sda_drv_r <= 1'b1;
                                state_r <= ST_AACK;
                            end else begin
                                state_r <= ST_WSTOP;
                            end
                        end
                    end
                    ST_AACK: begin
                        if (scl_fall) begin
                            sda_drv_r <= 1'b0;
                            state_r <= ST_HOLD;
                        end
                    end
                    ST_HOLD: begin
                        // scl is held low here until the buffer is serviced
                        if (release_ev) begin
                            cnt_r <= 4'h0;
                            hcf_r <= 1'b0;
                            address_match_flag_r <= 1'b0;
                            state_r <= ST_DATA;
                            // keep scl low one more cycle so the msb settles first
                            scl_hold_r <= 1'b1;
                            if (htx_r) begin
                                shift_r <= data_wr ? pwdata[7:0] : data_r;
                                sda_drv_r <= data_wr ? ~pwdata[7] : ~data_r[7];
                            end
                        end
                    end
                    ST_DATA: begin
                        if (scl_rise) begin
                            cnt_r <= cnt_r + 4'h1;
                            if (!htx_r) begin
                                shift_r <= shift_in;
                            end
                            if (last_bit) begin
                                hcf_r <= 1'b1;
                                serial_irq_req <= irq_en_r;
                                if (!htx_r) begin
                                    data_r <= shift_in;
                                end
                            end
                        end else if (scl_fall) begin
                            if (byte_done) begin
                                sda_drv_r <= htx_r ? 1'b0 : ~ack_to_send_r;
                                state_r <= ST_DACK;
                            end else if (htx_r) begin
                                shift_r <= {shift_r[6:0], 1'b0};
                                sda_drv_r <= ~shift_r[6];
                            end
                        end
                    end
                    ST_DACK: begin
                        if (scl_rise && htx_r) begin
                            ack_received_flag_r <= sda_s2_r;
                        end else if (scl_fall) begin
                            sda_drv_r <= 1'b0;
                            state_r <= (htx_r && ack_received_flag_r) ? ST_WSTOP : ST_HOLD;
                        end
                    end
                    ST_WSTOP: begin
                        sda_drv_r <= 1'b0;
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // pin drivers: open drain, only ever pulled low
    // ------------------------------------------------------------------------
    assign scl_out = 1'b0;
    // releasing scl in the cycle that sda changes would give the master no setup time
    assign scl_oe = active & ((state_r == ST_HOLD) | scl_hold_r);
    assign sda_out = 1'b0;
    assign sda_oe = active & sda_drv_r;

endmodule

// ==== i2css_defs.vh ====
// constants for the i2c slave serial port: register map, fields, reset values
`ifndef I2CSS_DEFS_VH
`define I2CSS_DEFS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define I2CSS_OFS_CTRL0 12'h000
`define I2CSS_OFS_CTRL1 12'h004
`define I2CSS_OFS_DATA 12'h008
`define I2CSS_OFS_ADDR 12'h00c
`define I2CSS_OFS_IRQC 12'h010

// ----------------------------------------------------------------------------
// interface_control_zero fields
// ----------------------------------------------------------------------------
`define I2CSS_C0_MODE_HI 7
`define I2CSS_C0_MODE_LO 5
`define I2CSS_C0_EN 1
`define I2CSS_MODE_I2C_SLAVE 3'h6
`define I2CSS_C0_RESET 8'he0
`define I2CSS_C0_WMASK 8'hfe

// ----------------------------------------------------------------------------
// interface_control_one fields
// ----------------------------------------------------------------------------
`define I2CSS_C1_HCF 7
`define I2CSS_C1_ADDRESS_MATCH_FLAG 6
`define I2CSS_C1_HBB 5
`define I2CSS_C1_HTX 4
`define I2CSS_C1_ACK_TO_SEND 3
`define I2CSS_C1_SRW 2
`define I2CSS_C1_WAKE 1
`define I2CSS_C1_ACK_RECEIVED_FLAG 0

// flag defaults, also restored when the interface is switched on
`define I2CSS_HCF_RESET 1'b1
`define I2CSS_ACK_RECEIVED_FLAG_RESET 1'b1

// ----------------------------------------------------------------------------
// other fields and reset values
// ----------------------------------------------------------------------------
`define I2CSS_IRQC_EN 0
`define I2CSS_DATA_RESET 8'h00
`define I2CSS_ADDR_RESET 8'h00
`define I2CSS_BITS_PER_BYTE 4'h8

`endif

// ==== i2css_checker.sv ====
// concurrent checks on the ports of the i2c slave serial port
`timescale 1ns/1ns
module i2css_checker #(
    parameter ADDR_W = 12
) (
    input wire core_clk,
    input wire reset_n,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire scl_in,
    input wire scl_out,
    input wire scl_oe,
    input wire sda_out,
    input wire sda_oe,
    input wire serial_irq_req
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------------
    a_ready_always: assert property (pready)
        else $error("apb ready low");
    // read data is only staged for reads, so a refused write may leave old data standing
    a_err_unmapped: assert property (psel && penable && paddr > 12'h010
        |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_err_mapped: assert property (psel && penable && paddr <= 12'h010 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");

    // ------------------------------------------------------------------
    // pins and interrupt
    // ------------------------------------------------------------------
    // open-drain pins: the slave may only pull low, never drive high
    a_pins_open_drain: assert property (!scl_out && !sda_out)
        else $error("pin driven high");
    a_irq_one_pulse: assert property (serial_irq_req |=> !serial_irq_req)
        else $error("interrupt longer than one cycle");
    a_irq_scl_high: assert property (serial_irq_req |-> scl_in && $past(scl_in, 2))
        else $error("interrupt not at an scl rise");
    // pulling sda while scl is high would forge a start condition
    a_sda_pull_low: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("sda pulled while scl high");
    a_ack_held: assert property ($rose(sda_oe) |=> sda_oe [*4])
        else $error("sda pull not held");
    a_stretch_low: assert property ($rose(scl_oe) |-> !$past(scl_in, 2))
        else $error("stretch started while scl high");
endmodule

bind i2css_slave i2css_checker #(.ADDR_W(ADDR_W)) i_chk (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
    .serial_irq_req(serial_irq_req)
);

// ==== i2css_master_model.sv ====
// behavioural i2c bus master driving the far side of the slave's pins
`timescale 1ns/1ns
module i2css_master_model #(
    parameter Q = 12
) (
    input wire scl,
    input wire sda,
    output logic scl_low,
    output logic sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // one clock: data set mid-low, a stretch is waited out, sample at end of high
    task clk(input logic bv, output logic s);
        #Q sda_low = !bv;
        #Q scl_low = 1'b0;
        wait (scl === 1'b1);
        #(2*Q-1) s = sda;
        #1 scl_low = 1'b1;
    endtask

    // start or repeated start: only the master ever makes one
    task start;
        #Q sda_low = 1'b0;
        #Q scl_low = 1'b0;
        wait (scl === 1'b1);
        #(2*Q) sda_low = 1'b1;
        #(2*Q) scl_low = 1'b1;
    endtask

    task stop;
        #Q sda_low = 1'b1;
        #Q scl_low = 1'b0;
        wait (scl === 1'b1);
        #(2*Q) sda_low = 1'b0;
        #(2*Q);
    endtask

    // byte msb first plus ninth clock; sending 8'hff leaves sda to the slave
    task xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) clk(d[i], q[i]);
        clk(ack_in, ack);
        #(4*Q);
    endtask
endmodule

// ==== i2c_slave_serial_port_test.sv ====
// self-checking bench: apb register access and i2c transfers from a master model
`timescale 1ns/1ns
`include "i2css_defs.vh"
module i2c_slave_serial_port_test;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, serial_irq_req, m_scl, m_sda;
    // pull-ups: a line is low while any party pulls it
    wire scl_in = !(m_scl | scl_oe);
    wire sda_in = !(m_sda | sda_oe);
    int miscompares = 0;
    int checked = 0;
    int irqs = 0;
    logic [31:0] q;
    logic err;
    logic [7:0] b;
    logic ack;

    always #2 core_clk = ~core_clk;
    always @(posedge core_clk) if (serial_irq_req === 1'b1) irqs <= irqs + 1;

    i2css_slave #(.ADDR_W(12)) i_dut (
        .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .serial_irq_req(serial_irq_req)
    );
    i2css_master_model #(.Q(12)) i_m (.scl(scl_in), .sda(sda_in), .scl_low(m_scl), .sda_low(m_sda));

    // ------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    task rdb(input int bi, input logic exp);
        apb(1'b0, `I2CSS_OFS_CTRL1, 32'h0);
        chk(q[bi], exp);
    endtask

    task end_of_test;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        #200000;
        miscompares++;
        end_of_test();
    end

    initial begin
        repeat (8) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(`I2CSS_OFS_CTRL0, 32'he0);
        rd(`I2CSS_OFS_CTRL1, 32'h81);
        rd(`I2CSS_OFS_ADDR, 32'h0);
        rd(12'h014, 32'h0);
        chk(err, 1'b1);
        wr(`I2CSS_OFS_CTRL0, 32'hc2);
        wr(`I2CSS_OFS_ADDR, 32'ha5);
        wr(`I2CSS_OFS_IRQC, 32'h1);
        rd(`I2CSS_OFS_ADDR, 32'ha5);
        i_m.start();
        rdb(`I2CSS_C1_HBB, 1'b1);
        i_m.xfer(8'ha4, 1'b1, b, ack);
        chk(ack, 1'b0);
        rdb(`I2CSS_C1_ADDRESS_MATCH_FLAG, 1'b1);
        rdb(`I2CSS_C1_SRW, 1'b0);
        chk(irqs, 1);
        apb(1'b0, `I2CSS_OFS_DATA, 32'h0);
        rdb(`I2CSS_C1_HCF, 1'b0);
        i_m.xfer(8'h3c, 1'b1, b, ack);
        chk(ack, 1'b0);
        rdb(`I2CSS_C1_HCF, 1'b1);
        wr(`I2CSS_OFS_CTRL1, 32'h08);
        rd(`I2CSS_OFS_DATA, 32'h3c);
        i_m.xfer(8'hc3, 1'b1, b, ack);
        chk(ack, 1'b1);
        rd(`I2CSS_OFS_DATA, 32'hc3);
        i_m.start();
        i_m.xfer(8'ha5, 1'b1, b, ack);
        chk(ack, 1'b0);
        rdb(`I2CSS_C1_SRW, 1'b1);
        wr(`I2CSS_OFS_CTRL1, 32'h10);
        wr(`I2CSS_OFS_DATA, 32'h96);
        i_m.xfer(8'hff, 1'b0, b, ack);
        chk(b, 8'h96);
        rdb(`I2CSS_C1_ACK_RECEIVED_FLAG, 1'b0);
        wr(`I2CSS_OFS_DATA, 32'h5a);
        i_m.xfer(8'hff, 1'b1, b, ack);
        chk(b, 8'h5a);
        rdb(`I2CSS_C1_ACK_RECEIVED_FLAG, 1'b1);
        i_m.stop();
        rdb(`I2CSS_C1_HBB, 1'b0);
        chk(irqs, 6);
        i_m.start();
        i_m.xfer(8'h60, 1'b1, b, ack);
        chk(ack, 1'b1);
        i_m.stop();
        chk(irqs, 6);
        end_of_test();
    end
endmodule
